// ==== core/nvs_pkg.sv ====
// Package: constants, types and timing for the non-volatile memory host controller
package nvs_pkg;
  localparam int CLK_PERIOD_NS = 10;
  // Device timing, printed units
  localparam int WRITE_GRACE_TIME_NS = 25;
  localparam int STORE_REQUEST_PULSE_NS = 15;
  localparam int BUSY_RELEASE_TIME_NS = 25;
  localparam int SOFT_COMMAND_TIME_US = 100;
  localparam int ACCESS_TIME_NS = 25;
  localparam int WRITE_PULSE_NS = 20;
  // Cycle counts: every time, least or longest, rounds up
  localparam int STORE_PULSE_CYC = (STORE_REQUEST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUSY_RELEASE_CYC = (BUSY_RELEASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACCESS_CYC = (ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SOFT_CMD_CYC = (SOFT_COMMAND_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int NUM_SEQ_STEPS = 6;
  localparam int ADDR_W = 19;
  localparam int DATA_W = 16;
  localparam int CNT_W = 16;

  typedef enum logic [3:0] {
    NVS_IDLE = 4'h0,
    NVS_RD_ACT = 4'h1,
    NVS_RD_END = 4'h2,
    NVS_WR_ACT = 4'h3,
    NVS_WR_END = 4'h4,
    NVS_SEQ_ACT = 4'h5,
    NVS_SEQ_END = 4'h6,
    NVS_SEQ_WAIT = 4'h7,
    NVS_HS_PULSE = 4'h8,
    NVS_HS_WAIT = 4'h9
  } nvs_state_e;

  typedef enum logic [1:0] {
    NVS_OP_READ = 2'h0,
    NVS_OP_WRITE = 2'h1,
    NVS_OP_SOFT = 2'h2,
    NVS_OP_HWSTORE = 2'h3
  } nvs_op_e;

  typedef struct packed {
    nvs_op_e op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [1:0] lanes;
  } nvs_req_s;

  typedef struct packed {
    logic chip_select_n;
    logic write_strobe_n;
    logic output_drive_n;
    logic upper_byte_sel_n;
    logic lower_byte_sel_n;
    logic [ADDR_W-1:0] addr;
  } nvs_pins_s;
endpackage

// ==== core/nvs_timer.sv ====
// Down counter used for all pin timing of the host controller
`timescale 1ns/1ps
`default_nettype none
module nvs_timer #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // Control
  input wire logic load_in,
  input wire logic [WIDTH-1:0] count_in,
  // Status
  output logic done_out
);
  typedef struct packed {
    logic [WIDTH-1:0] cnt;
  } nvs_tmr_s;
  nvs_tmr_s st_r;
  nvs_tmr_s st_nxt;
  always_comb begin
    st_nxt = st_r;
    if (load_in) begin
      st_nxt.cnt = count_in;
    end else if (st_r.cnt != '0) begin
      st_nxt.cnt = st_r.cnt - 1'b1;
    end
  end
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  // Done looks at the count only, so a load decided on done cannot loop back
  assign done_out = (st_r.cnt == '0);
endmodule
`default_nettype wire

// ==== core/nvs_host_ctl.sv ====
// Host controller driving the pins of an asynchronous non-volatile static memory
// Behaviour
// [RULE1] Each soft command step is a read whose chip select edge advances the sequence.
// [RULE2] Six reads to six given addresses, back to back, in order.
// [RULE3] Write strobe stays high through all six command reads.
// [RULE4] Data of the sixth command read may be invalid and is discarded.
// [RULE5] Device acts on a soft command within 100 us after sixth read.
// [RULE6] Store or recall locks the data port until finished.
// [RULE7] Hardware store request drives store busy low at least 15 ns.
// [RULE8] Store skipped without prior write; busy released within 20 or 25 ns.
// [RULE9] Device tracks a write latch; no store without a write.
// [RULE10] Store busy held high during ordinary reads and writes.
// [RULE11] Chip select high: other controls ignored, data floats, standby.
// [RULE12] Byte build read drives data 0 to 7; output drive high floats.
// [RULE13] Byte build write takes data 0 to 7 whatever output drive does.
// [RULE14] Word build both selects low drive 16 lines; both high disable.
// [RULE15] Lower select enables lines 0 to 7, upper lines 8 to 15.
// [RULE16] Word write with both selects low writes all 16 lines.
// [RULE17] Byte selects exist only in the word build.
// [RULE18] Device ignores accesses during store, recall or low supply.
// [RULE19] Write in progress completes within grace time after store starts.
// [RULE20] Mismatching read or any write resets the device sequence count.
// [RULE21] Device holds store busy low for a whole store.
`timescale 1ns/1ps
`default_nettype none
module nvs_host_ctl
  import nvs_pkg::*;
#(
  parameter int WORD_BUILD = 1,
  parameter int SOFT_CMD_CYCLES = SOFT_CMD_CYC,
  parameter int BUSY_TIMEOUT_CYCLES = 1000000,
  parameter logic [nvs_pkg::ADDR_W-1:0] SEQ_ADDR0 = 19'h00000,
  parameter logic [nvs_pkg::ADDR_W-1:0] SEQ_ADDR1 = 19'h00001,
  parameter logic [nvs_pkg::ADDR_W-1:0] SEQ_ADDR2 = 19'h00002,
  parameter logic [nvs_pkg::ADDR_W-1:0] SEQ_ADDR3 = 19'h00003,
  parameter logic [nvs_pkg::ADDR_W-1:0] SEQ_ADDR4 = 19'h00004,
  parameter logic [nvs_pkg::ADDR_W-1:0] SEQ_ADDR5 = 19'h00005
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // User request
  input wire logic req_valid_in,
  input wire nvs_pkg::nvs_req_s req_in,
  output logic req_ready_out,
  // User answer
  output logic rsp_valid_out,
  output logic [nvs_pkg::DATA_W-1:0] rsp_data_out,
  output logic rsp_timeout_out,
  // Memory control pins
  output var nvs_pkg::nvs_pins_s pins_out,
  // Memory data pins
  input wire logic [nvs_pkg::DATA_W-1:0] data_in,
  output logic [nvs_pkg::DATA_W-1:0] data_out,
  output logic [1:0] data_oe_out,
  // Store busy pin, open drain
  input wire logic store_busy_n_in,
  output logic store_busy_n_out,
  output logic store_busy_oe_out
);
  import nvs_pkg::*;

  if (WORD_BUILD != 0 && WORD_BUILD != 1) begin : g_bad_build
    $error("WORD_BUILD must be 0 or 1");
  end
  if (SOFT_CMD_CYCLES < 1 || SOFT_CMD_CYCLES >= (1 << 20)) begin : g_bad_soft
    $error("SOFT_CMD_CYCLES out of range");
  end
  if (BUSY_TIMEOUT_CYCLES < 1 || BUSY_TIMEOUT_CYCLES >= (1 << 20)) begin : g_bad_busy
    $error("BUSY_TIMEOUT_CYCLES out of range");
  end

  localparam int TW = 20;
  localparam logic [TW-1:0] ACC_T = TW'(ACCESS_CYC);
  localparam logic [TW-1:0] WR_T = TW'(WRITE_CYC);
  localparam logic [TW-1:0] PULSE_T = TW'(STORE_PULSE_CYC);
  localparam logic [TW-1:0] REL_T = TW'(BUSY_RELEASE_CYC);
  localparam logic [TW-1:0] SOFT_T = TW'(SOFT_CMD_CYCLES);
  localparam logic [TW-1:0] BUSY_T = TW'(BUSY_TIMEOUT_CYCLES);
  localparam logic [2:0] LAST_STEP = 3'(NUM_SEQ_STEPS - 1);

  typedef struct packed {
    nvs_state_e state;
    logic [2:0] step;
    logic ready;
    logic rsp_valid;
    logic [DATA_W-1:0] rsp_data;
    logic timeout;
    nvs_pins_s pins;
    logic [DATA_W-1:0] dout;
    logic [1:0] doe;
    logic hs_oe;
  } nvs_st_s;

  nvs_st_s st_r;
  nvs_st_s st_nxt;
  logic tmr_load;
  logic [TW-1:0] tmr_count;
  logic tmr_done;
  logic [ADDR_W-1:0] seq_addr;

  nvs_timer #(.WIDTH(TW)) u_timer (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .load_in(tmr_load),
    .count_in(tmr_count),
    .done_out(tmr_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Address of the step that follows the current one
  always_comb begin
    unique case (st_r.step)
      3'h0: seq_addr = SEQ_ADDR1;
      3'h1: seq_addr = SEQ_ADDR2;
      3'h2: seq_addr = SEQ_ADDR3;
      3'h3: seq_addr = SEQ_ADDR4;
      default: seq_addr = SEQ_ADDR5;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_nxt = st_r;
    st_nxt.rsp_valid = 1'b0;
    tmr_load = 1'b0;
    tmr_count = '0;
    unique case (st_r.state)
      NVS_IDLE: begin
        // Deselected: device ignores every other control
        st_nxt.pins.chip_select_n = 1'b1; // [RULE11]
        st_nxt.pins.write_strobe_n = 1'b1;
        st_nxt.pins.output_drive_n = 1'b1;
        st_nxt.doe = 2'b00;
        if (req_valid_in && st_r.ready) begin
          st_nxt.ready = 1'b0;
          st_nxt.timeout = 1'b0;
          // Byte build has no lane selects; both held low
          st_nxt.pins.upper_byte_sel_n = (WORD_BUILD != 0) ? !req_in.lanes[1] : 1'b0; // [RULE15] [RULE17]
          st_nxt.pins.lower_byte_sel_n = (WORD_BUILD != 0) ? !req_in.lanes[0] : 1'b0; // [RULE15]
          st_nxt.pins.addr = req_in.addr;
          st_nxt.step = 3'h0;
          tmr_load = 1'b1;
          unique case (req_in.op)
            NVS_OP_READ: begin
              st_nxt.pins.chip_select_n = 1'b0;
              st_nxt.pins.output_drive_n = 1'b0; // [RULE12]
              tmr_count = ACC_T;
              st_nxt.state = NVS_RD_ACT;
            end
            NVS_OP_WRITE: begin
              st_nxt.pins.chip_select_n = 1'b0;
              st_nxt.pins.write_strobe_n = 1'b0; // [RULE13]
              st_nxt.dout = req_in.wdata;
              // Drive only selected lanes; unselected lane floats
              st_nxt.doe = (WORD_BUILD != 0) ? req_in.lanes : 2'b01; // [RULE16]
              tmr_count = WR_T;
              st_nxt.state = NVS_WR_ACT;
            end
            NVS_OP_SOFT: begin
              st_nxt.pins.chip_select_n = 1'b0;
              st_nxt.pins.output_drive_n = 1'b0;
              st_nxt.pins.upper_byte_sel_n = 1'b0; // [RULE14]
              st_nxt.pins.lower_byte_sel_n = 1'b0; // [RULE14]
              st_nxt.pins.addr = SEQ_ADDR0; // [RULE2]
              tmr_count = ACC_T;
              st_nxt.state = NVS_SEQ_ACT;
            end
            default: begin
              st_nxt.hs_oe = 1'b1; // [RULE7]
              tmr_count = PULSE_T;
              st_nxt.state = NVS_HS_PULSE;
            end
          endcase
        end
      end
      NVS_RD_ACT: begin
        if (tmr_done) begin
          st_nxt.rsp_data = data_in;
          st_nxt.pins.chip_select_n = 1'b1;
          st_nxt.pins.output_drive_n = 1'b1;
          st_nxt.state = NVS_RD_END;
        end
      end
      NVS_WR_ACT: begin
        if (tmr_done) begin
          // Write ends on strobe rise; data held one more cycle for hold time
          st_nxt.pins.write_strobe_n = 1'b1;
          st_nxt.pins.chip_select_n = 1'b1;
          st_nxt.state = NVS_WR_END;
        end
      end
      NVS_RD_END, NVS_WR_END: begin
        st_nxt.doe = 2'b00;
        st_nxt.rsp_valid = 1'b1;
        st_nxt.ready = 1'b1;
        st_nxt.state = NVS_IDLE;
      end
      NVS_SEQ_ACT: begin
        // Strobe held high throughout; chip select rise clocks the step
        st_nxt.pins.write_strobe_n = 1'b1; // [RULE3]
        if (tmr_done) begin
          st_nxt.pins.chip_select_n = 1'b1; // [RULE1]
          st_nxt.pins.output_drive_n = 1'b1;
          st_nxt.state = NVS_SEQ_END;
        end
      end
      NVS_SEQ_END: begin
        tmr_load = 1'b1;
        if (st_r.step == LAST_STEP) begin
          // Sixth read data not captured: outputs may be off
          tmr_count = SOFT_T; // [RULE4]
          st_nxt.state = NVS_SEQ_WAIT;
        end else begin
          st_nxt.step = st_r.step + 3'h1;
          st_nxt.pins.addr = seq_addr; // [RULE2]
          st_nxt.pins.chip_select_n = 1'b0;
          st_nxt.pins.output_drive_n = 1'b0;
          tmr_count = ACC_T;
          st_nxt.state = NVS_SEQ_ACT;
        end
      end
      NVS_SEQ_WAIT: begin
        // Port stays deselected for the whole processing window
        if (tmr_done) begin // [RULE5]
          tmr_load = 1'b1;
          tmr_count = BUSY_T;
          st_nxt.state = NVS_HS_WAIT;
        end
      end
      NVS_HS_PULSE: begin
        if (tmr_done) begin
          st_nxt.hs_oe = 1'b0;
          tmr_load = 1'b1;
          tmr_count = REL_T;
          st_nxt.state = NVS_HS_WAIT;
        end
      end
      NVS_HS_WAIT: begin
        // Store or recall locks the port; wait for busy to read high
        if (tmr_done) begin // [RULE6]
          if (store_busy_n_in) begin // [RULE21]
            st_nxt.rsp_valid = 1'b1;
            st_nxt.ready = 1'b1;
            st_nxt.state = NVS_IDLE;
          end else begin
            tmr_load = 1'b1;
            tmr_count = BUSY_T;
            st_nxt.timeout = 1'b1;
          end
        end else if (st_r.timeout && store_busy_n_in) begin
          st_nxt.rsp_valid = 1'b1;
          st_nxt.ready = 1'b1;
          st_nxt.state = NVS_IDLE;
        end
      end
      default: begin
        st_nxt.state = NVS_IDLE;
        st_nxt.ready = 1'b1;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_r <= '0;
      st_r.state <= NVS_IDLE;
      st_r.ready <= 1'b1;
      st_r.pins <= '1;
      st_r.pins.addr <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign req_ready_out = st_r.ready;
  assign rsp_valid_out = st_r.rsp_valid;
  assign rsp_data_out = st_r.rsp_data;
  assign rsp_timeout_out = st_r.timeout;
  assign pins_out = st_r.pins;
  assign data_out = st_r.dout;
  assign data_oe_out = st_r.doe;
  // Busy pin only pulled low; high otherwise, also during ordinary cycles
  assign store_busy_n_out = 1'b0; // [RULE10]
  assign store_busy_oe_out = st_r.hs_oe; // [RULE10]
endmodule
`default_nettype wire

// ==== tb/nvs_hc_checker.sv ====
// Pin-side assertions for the non-volatile memory host controller
`timescale 1ns/1ps
`default_nettype none
module nvs_hc_checker
  import nvs_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // Watched ports
  input wire logic req_ready_out,
  input wire logic rsp_valid_out,
  input wire nvs_pkg::nvs_pins_s pins_out,
  input wire logic store_busy_n_out,
  input wire logic store_busy_oe_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  read_no_write_a: assert property (!pins_out.output_drive_n |-> pins_out.write_strobe_n)
    else $error("write strobe low during a read");
  read_by_oe_a: assert property (!pins_out.chip_select_n && pins_out.write_strobe_n |-> !pins_out.output_drive_n)
    else $error("selected read without output drive");
  read_hold_a: assert property ($fell(pins_out.chip_select_n) && pins_out.write_strobe_n |->
    (!pins_out.chip_select_n)[*3]) else $error("read strobe too short");
  addr_steady_a: assert property (!pins_out.chip_select_n && !$past(pins_out.chip_select_n) |->
    $stable(pins_out.addr)) else $error("address moved while selected");
  busy_quiet_a: assert property (!pins_out.chip_select_n |-> !store_busy_oe_out)
    else $error("store busy pulled during access");
  busy_pulse_a: assert property ($rose(store_busy_oe_out) |=> store_busy_oe_out)
    else $error("store request pulse too short");
  busy_drain_a: assert property (store_busy_oe_out |-> !store_busy_n_out)
    else $error("store busy driven high");
  done_ready_a: assert property (rsp_valid_out |-> req_ready_out ##1 !rsp_valid_out)
    else $error("answer pulse malformed");
endmodule
bind nvs_host_ctl nvs_hc_checker u_nvs_hc_checker (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
  .req_ready_out(req_ready_out), .rsp_valid_out(rsp_valid_out), .pins_out(pins_out),
  .store_busy_n_out(store_busy_n_out), .store_busy_oe_out(store_busy_oe_out));
`default_nettype wire

// ==== tb/nvs_mem_model.sv ====
// Behavioural word-wide non-volatile memory facing the host controller
`timescale 1ns/1ps
`default_nettype none
module nvs_mem_model
  import nvs_pkg::*;
#(
  parameter int STORE_CYC = 80,
  parameter int LOCK_CYC = 10,
  parameter logic [18:0] SEQ_BASE = 19'h00000
) (
  // Clock
  input wire logic clk_sys_in,
  // Pins from host
  input wire nvs_pkg::nvs_pins_s pins_in,
  input wire logic [15:0] wdata_in,
  input wire logic busy_n_in,
  // Pins to host
  output logic [15:0] rdata_out,
  output logic [1:0] rdata_oe_out,
  output logic busy_oe_out
);
  logic [15:0] mem [0:255];
  nvs_pins_s prev_r = '1;
  logic latch_r = 1'b0;
  int lock_r = 0;
  int store_r = 0;
  int seq_cnt = 0;
  int cmd_cnt = 0;
  int store_cnt = 0;
  logic [7:0] a;
  initial for (int i = 0; i < 256; i++) mem[i] = 16'h0000;
  assign a = pins_in.addr[7:0];
  assign rdata_oe_out = (!pins_in.chip_select_n && pins_in.write_strobe_n && !pins_in.output_drive_n &&
    lock_r == 0 && store_r == 0) ? {!pins_in.upper_byte_sel_n, !pins_in.lower_byte_sel_n} : 2'h0;
  // Released lanes show the inverse so a stale value never passes
  assign rdata_out = mem[a] ^ {{8{!rdata_oe_out[1]}}, {8{!rdata_oe_out[0]}}};
  assign busy_oe_out = store_r != 0;
  always @(posedge clk_sys_in) begin
    prev_r <= pins_in;
    if (lock_r != 0) lock_r <= lock_r - 1;
    if (store_r != 0) store_r <= store_r - 1;
    else if (lock_r == 0) begin
      if (!busy_n_in && latch_r) begin
        store_r <= STORE_CYC;
        latch_r <= 1'b0;
        store_cnt++;
      end
      // A write in the cycle a store starts still lands
      if (!pins_in.chip_select_n && !pins_in.write_strobe_n) begin
        if (!pins_in.lower_byte_sel_n) mem[a][7:0] <= wdata_in[7:0];
        if (!pins_in.upper_byte_sel_n) mem[a][15:8] <= wdata_in[15:8];
        latch_r <= 1'b1;
        seq_cnt <= 0;
      end else if (!prev_r.chip_select_n && prev_r.write_strobe_n && pins_in.chip_select_n) begin
        if (prev_r.addr != SEQ_BASE + 19'(seq_cnt)) seq_cnt <= 0;
        else if (seq_cnt == 5) begin
          seq_cnt <= 0;
          cmd_cnt++;
          lock_r <= LOCK_CYC;
        end else seq_cnt <= seq_cnt + 1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/nvs_host_ctl_test.sv ====
// Self-checking bench for the non-volatile memory host controller
`timescale 1ns/1ps
`default_nettype none
module nvs_host_ctl_test;
  import nvs_pkg::*;
  logic clk_sys_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic req_valid_in = 1'b0;
  nvs_req_s req_in = '0;
  logic req_ready_out, rsp_valid_out, rsp_timeout_out, store_busy_n_out, store_busy_oe_out, busy_wire, dev_busy;
  logic [15:0] rsp_data_out, data_out, data_in, dev_data, v, w;
  logic [1:0] data_oe_out, dev_oe;
  nvs_pins_s pins_out;
  logic [17:0] exp_q [$];
  logic [17:0] e;
  int fail_count = 0;
  int num_checks = 0;
  always #5 clk_sys_in = ~clk_sys_in;
  // Busy has a pull-up; each lane is driven by whoever enables it
  assign busy_wire = (store_busy_oe_out ? store_busy_n_out : 1'b1) && !dev_busy;
  assign data_in = {data_oe_out[1] ? data_out[15:8] : dev_data[15:8], data_oe_out[0] ? data_out[7:0] : dev_data[7:0]};
  nvs_host_ctl #(.WORD_BUILD(1), .SOFT_CMD_CYCLES(20), .BUSY_TIMEOUT_CYCLES(50)) u_nvs_host_ctl (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .req_valid_in(req_valid_in), .req_in(req_in),
    .req_ready_out(req_ready_out), .rsp_valid_out(rsp_valid_out), .rsp_data_out(rsp_data_out),
    .rsp_timeout_out(rsp_timeout_out), .pins_out(pins_out), .data_in(data_in), .data_out(data_out),
    .data_oe_out(data_oe_out), .store_busy_n_in(busy_wire), .store_busy_n_out(store_busy_n_out),
    .store_busy_oe_out(store_busy_oe_out));
  nvs_mem_model u_nvs_mem_model (.clk_sys_in(clk_sys_in), .pins_in(pins_out), .wdata_in(data_out),
    .busy_n_in(busy_wire), .rdata_out(dev_data), .rdata_oe_out(dev_oe), .busy_oe_out(dev_busy));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t %s: saw %h want %h", $time, what, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Bounded wait for ready, and optionally for all answers
  task automatic wait_for(input bit drain);
    int n = 0;
    @(negedge clk_sys_in);
    while (req_ready_out !== 1'b1 || (drain && exp_q.size() != 0)) begin
      @(negedge clk_sys_in);
      n++;
      if (n > 2000) begin
        check(16'h0001, 16'h0000, "wait ran out");
        print_verdict();
      end
    end
  endtask
  task automatic send(input nvs_op_e op, input int addr, input logic [15:0] wd, input logic [1:0] ln,
      input logic [17:0] exp);
    wait_for(0);
    exp_q.push_back(exp);
    req_in = '{op: op, addr: 19'(addr), wdata: wd, lanes: ln};
    req_valid_in = 1'b1;
    @(negedge clk_sys_in);
    req_valid_in = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(negedge clk_sys_in) begin
    if (rst_n_in && rsp_valid_out === 1'b1) begin
      if (exp_q.size() == 0) check(16'h0001, 16'h0000, "unexpected answer");
      else begin
        e = exp_q.pop_front();
        check({15'h0, rsp_timeout_out}, {15'h0, e[16]}, "timeout flag");
        if (e[17]) check(rsp_data_out, e[15:0], "read data");
      end
    end
    // Host and memory must never drive the same lane
    if (rst_n_in && (dev_oe & data_oe_out) != 2'h0) check({14'h0, dev_oe & data_oe_out}, 16'h0000, "lane clash");
  end
  initial begin
    void'($urandom(18));
    repeat (16) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    rst_n_in = 1'b1;
    for (int i = 16; i < 24; i++) send(NVS_OP_WRITE, i, 16'(i * 16'h1111), 2'h3, 18'h0);
    for (int i = 16; i < 24; i++) send(NVS_OP_READ, i, 16'h0, 2'h3, {2'h2, 16'(i * 16'h1111)});
    wait_for(1);
    $display("done: word access");
    v = 16'($urandom());
    w = 16'($urandom());
    send(NVS_OP_WRITE, 30, v, 2'h1, 18'h0);
    send(NVS_OP_WRITE, 30, w, 2'h2, 18'h0);
    send(NVS_OP_READ, 30, 16'h0, 2'h3, {2'h2, w[15:8], v[7:0]});
    wait_for(1);
    $display("done: byte lanes");
    send(NVS_OP_HWSTORE, 0, 16'h0, 2'h0, 18'h10000);
    wait_for(1);
    check(16'(u_nvs_mem_model.store_cnt), 16'h0001, "store count");
    send(NVS_OP_HWSTORE, 0, 16'h0, 2'h0, 18'h0);
    wait_for(1);
    check(16'(u_nvs_mem_model.store_cnt), 16'h0001, "skipped store");
    $display("done: hardware store");
    send(NVS_OP_READ, 0, 16'h0, 2'h3, 18'h20000);
    wait_for(1);
    check(16'(u_nvs_mem_model.seq_cnt), 16'h0001, "sequence step");
    send(NVS_OP_READ, 9, 16'h0, 2'h3, 18'h20000);
    wait_for(1);
    check(16'(u_nvs_mem_model.seq_cnt), 16'h0000, "sequence reset");
    send(NVS_OP_SOFT, 0, 16'h0, 2'h3, 18'h0);
    wait_for(1);
    check(16'(u_nvs_mem_model.cmd_cnt), 16'h0001, "command taken");
    $display("done: soft command");
    print_verdict();
  end
endmodule
`default_nettype wire
